/* File: hdl/smon_pkg.sv */
// Contract
// - Normal state is always available, even with no threshold enabled.
// - Only upper critical enabled gives exactly normal and above upper critical.
// - Upper warning plus upper critical enabled gives normal, above warning, above critical.
// - Above upper warning and below lower warning are warning severity.
// - Above upper critical and below lower critical are critical severity.
// - With several states available, a move to a worse state raises an assertion.
// - A worse state must persist for the assertion timeout, in samples, first.
// - A state change before the timeout ends cancels the pending assertion.
// - A timeout of zero asserts at once.
// - Ordinary sensors are sampled once per second.
// - The slow sensor class samples every three seconds.
// - Improving transitions raise a de-assertion event.
// - Upper de-assertion level is threshold minus hysteresis.
// - Lower de-assertion level is threshold plus hysteresis.
// - De-assert only at or past the de-assertion level; in between stays asserted.
// - Zero hysteresis makes the threshold itself the de-assertion level.
// - Four thresholds with own enables: lower critical, lower warning, upper warning, critical.
// - Above warning when over upper warning but not over upper critical; else above critical.
// - Below warning when at/above lower critical but under lower warning; else below critical.
package smon_pkg;

    // ==========================================================
    // Widths and register map
    localparam int DW = 16;
    localparam int AW = 4;
    localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [AW-1:0] ADDR_THR_LC = 4'h1;
    localparam logic [AW-1:0] ADDR_THR_LW = 4'h2;
    localparam logic [AW-1:0] ADDR_THR_UW = 4'h3;
    localparam logic [AW-1:0] ADDR_THR_UC = 4'h4;
    localparam logic [AW-1:0] ADDR_HYST = 4'h5;
    localparam logic [AW-1:0] ADDR_TMO = 4'h6;
    localparam logic [AW-1:0] ADDR_STAT = 4'h7;

    // ==========================================================
    // Field positions and reset values
    localparam int THR_LC = 0;
    localparam int THR_LW = 1;
    localparam int THR_UW = 2;
    localparam int THR_UC = 3;
    localparam int CTRL_SLOW = 4;
    localparam logic [3:0] EN_RST = 4'h0;
    localparam logic [DW-1:0] THR_RST = 16'h0000;
    localparam logic [DW-1:0] HYST_RST = 16'h0000;
    localparam logic [DW-1:0] TMO_RST = 16'h0000;
    localparam logic [DW-1:0] CNT_RST = 16'h0000;

    // ==========================================================
    // Sample timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SAMPLE_PERIOD_S = 1;
    localparam int SLOW_SAMPLE_S = 3;
    localparam int SEC_CYCLES = SAMPLE_PERIOD_S * 1000000000 / CLK_PERIOD_NS;
    localparam int SLOW_MULT = SLOW_SAMPLE_S / SAMPLE_PERIOD_S;

    // ==========================================================
    // States and severities
    typedef enum logic [4:0] {
        ST_NORMAL = 5'b00001,
        ST_UW = 5'b00010,
        ST_UC = 5'b00100,
        ST_LW = 5'b01000,
        ST_LC = 5'b10000
    } smon_state_t;

    localparam logic [1:0] SEV_NORMAL = 2'h0;
    localparam logic [1:0] SEV_WARN = 2'h1;
    localparam logic [1:0] SEV_CRIT = 2'h2;

    typedef struct packed {
        logic asrt;
        logic dasrt;
        smon_state_t state;
    } smon_evt_t;

    typedef struct packed {
        logic [3:0] en;
        logic slow;
        logic [DW-1:0] hyst;
        logic [DW-1:0] tmo;
    } smon_cfg_t;

endpackage

/* File: hdl/smon_tick.sv */
`timescale 1ns/10ps
module smon_tick import smon_pkg::*; #(
    parameter int CYC_PER_SEC = SEC_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    output logic tick_o
);

    localparam logic [31:0] LIM_FAST = 32'(CYC_PER_SEC - 1);
    localparam logic [31:0] LIM_SLOW = 32'(CYC_PER_SEC * SLOW_MULT - 1);

    logic [31:0] cnt_reg;
    wire [31:0] lim = slow_i ? LIM_SLOW : LIM_FAST;
    // Compare with >= so a class change mid-period cannot strand the counter
    wire wrap = (cnt_reg >= lim);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
            tick_o <= wrap;
        end
    end

    AST_TICK_SPACING: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tick_o |=> !tick_o)
        else $error("sample tick lasted more than one cycle");

endmodule

/* File: hdl/smon_top.sv */
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module smon_top import smon_pkg::*; #(
    parameter int CYC_PER_SEC = SEC_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DW-1:0] rdata_o,
    input wire logic signed [DW-1:0] reading_i,
    output logic sample_o,
    output smon_evt_t evt_o,
    output smon_state_t state_o,
    output logic [1:0] severity_o,
    output logic pending_o
);

    // ==========================================================
    // Register file
    smon_cfg_t cfg_reg;
    logic signed [DW-1:0] thr_reg [4];

    wire wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
    wire wr_hyst = wr_i && (addr_i == ADDR_HYST);
    wire wr_tmo = wr_i && (addr_i == ADDR_TMO);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_reg.en <= EN_RST;
            cfg_reg.slow <= 1'b0;
            cfg_reg.hyst <= HYST_RST;
            cfg_reg.tmo <= TMO_RST;
        end else begin
            if (wr_ctrl) begin
                cfg_reg.en <= wdata_i[3:0];
                cfg_reg.slow <= wdata_i[CTRL_SLOW];
            end
            if (wr_hyst) begin
                cfg_reg.hyst <= wdata_i;
            end
            if (wr_tmo) begin
                cfg_reg.tmo <= wdata_i;
            end
        end
    end

    // ==========================================================
    // Sample tick
    logic tick;

    smon_tick #(
        .CYC_PER_SEC(CYC_PER_SEC)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .slow_i(cfg_reg.slow),
        .tick_o(tick)
    );

    // ==========================================================
    // Per-threshold compare
    // Indices 0..1 are lower thresholds, 2..3 upper ones
    logic [3:0] beyond;
    logic [3:0] cleared;
    wire signed [DW:0] rd_ext = {reading_i[DW-1], reading_i};
    wire signed [DW:0] hy_ext = {1'b0, cfg_reg.hyst};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_thr
            wire wr_thr = wr_i && (addr_i == AW'(gi + 1));
            wire signed [DW:0] th_ext = {thr_reg[gi][DW-1], thr_reg[gi]};
            // Extra bit keeps threshold +/- hysteresis from wrapping for hysteresis up to 32768
            wire signed [DW:0] dlev;
            if (gi >= THR_UW) begin : g_up
                assign dlev = th_ext - hy_ext;
                assign beyond[gi] = rd_ext > th_ext;
                assign cleared[gi] = rd_ext <= dlev;
            end else begin : g_lo
                assign dlev = th_ext + hy_ext;
                assign beyond[gi] = rd_ext < th_ext;
                assign cleared[gi] = rd_ext >= dlev;
            end
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    thr_reg[gi] <= THR_RST;
                end else if (wr_thr) begin
                    thr_reg[gi] <= wdata_i;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Classification
    wire [3:0] hit = beyond & cfg_reg.en;
    smon_state_t raw;
    assign raw = hit[THR_UC] ? ST_UC :
                 hit[THR_UW] ? ST_UW :
                 hit[THR_LC] ? ST_LC :
                 hit[THR_LW] ? ST_LW : ST_NORMAL;

    function automatic logic [1:0] sev_of(input smon_state_t s);
        case (s)
            ST_UW, ST_LW: sev_of = SEV_WARN;
            ST_UC, ST_LC: sev_of = SEV_CRIT;
            default: sev_of = SEV_NORMAL;
        endcase
    endfunction

    // ==========================================================
    // Asserted state and pending assertion
    smon_state_t state_reg;
    smon_state_t state_next;
    smon_state_t pend_st_reg;
    smon_state_t pend_st_next;
    logic pend_vld_reg;
    logic pend_vld_next;
    logic [DW-1:0] cnt_reg;
    logic [DW-1:0] cnt_next;
    smon_evt_t evt_next;

    // Whether the threshold of the current asserted state is enabled and still holds it
    logic hold_ok;
    always_comb begin
        case (state_reg)
            ST_UC: hold_ok = cfg_reg.en[THR_UC] && !cleared[THR_UC];
            ST_UW: hold_ok = cfg_reg.en[THR_UW] && !cleared[THR_UW];
            ST_LW: hold_ok = cfg_reg.en[THR_LW] && !cleared[THR_LW];
            ST_LC: hold_ok = cfg_reg.en[THR_LC] && !cleared[THR_LC];
            default: hold_ok = 1'b0;
        endcase
    end

    wire raw_better = sev_of(raw) < sev_of(state_reg);
    smon_state_t cand;
    // Stay asserted until the reading reaches or passes the de-assertion level
    assign cand = (raw_better && hold_ok) ? state_reg : raw;
    wire cand_better = sev_of(cand) < sev_of(state_reg);
    wire cand_worse = (cand != state_reg) && !cand_better;
    wire tmo_zero = (cfg_reg.tmo == TMO_RST);
    wire same_pend = pend_vld_reg && (pend_st_reg == cand);
    wire cnt_done = (cnt_reg + 16'h0001) == cfg_reg.tmo;

    always_comb begin
        state_next = state_reg;
        pend_st_next = pend_st_reg;
        pend_vld_next = pend_vld_reg;
        cnt_next = cnt_reg;
        evt_next = '{asrt: 1'b0, dasrt: 1'b0, state: state_reg};
        if (tick) begin
            if (cand == state_reg) begin
                // Reading went back before timeout: drop the wait
                pend_vld_next = 1'b0;
            end else if (cand_better) begin
                state_next = cand;
                pend_vld_next = 1'b0;
                evt_next = '{asrt: 1'b0, dasrt: 1'b1, state: cand};
            end else if (tmo_zero) begin
                state_next = cand;
                pend_vld_next = 1'b0;
                evt_next = '{asrt: 1'b1, dasrt: 1'b0, state: cand};
            end else if (same_pend) begin
                if (cnt_done) begin
                    state_next = cand;
                    pend_vld_next = 1'b0;
                    evt_next = '{asrt: 1'b1, dasrt: 1'b0, state: cand};
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end else begin
                // New or changed worse state restarts the wait
                pend_vld_next = 1'b1;
                pend_st_next = cand;
                cnt_next = CNT_RST;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_NORMAL;
            pend_st_reg <= ST_NORMAL;
            pend_vld_reg <= 1'b0;
            cnt_reg <= CNT_RST;
        end else begin
            state_reg <= state_next;
            pend_st_reg <= pend_st_next;
            pend_vld_reg <= pend_vld_next;
            cnt_reg <= cnt_next;
        end
    end

    // ==========================================================
    // Outputs, all registered
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            evt_o <= '{asrt: 1'b0, dasrt: 1'b0, state: ST_NORMAL};
            state_o <= ST_NORMAL;
            severity_o <= SEV_NORMAL;
            pending_o <= 1'b0;
            sample_o <= 1'b0;
        end else begin
            evt_o <= evt_next;
            state_o <= state_next;
            severity_o <= sev_of(state_next);
            pending_o <= pend_vld_next;
            sample_o <= tick;
        end
    end

    // ==========================================================
    // Read back
    wire [DW-1:0] stat_word = {3'h0, raw, pend_vld_reg, sev_of(state_reg), state_reg};
    logic [DW-1:0] rd_mux;
    always_comb begin
        case (addr_i)
            ADDR_CTRL: rd_mux = {11'h000, cfg_reg.slow, cfg_reg.en};
            ADDR_THR_LC: rd_mux = thr_reg[THR_LC];
            ADDR_THR_LW: rd_mux = thr_reg[THR_LW];
            ADDR_THR_UW: rd_mux = thr_reg[THR_UW];
            ADDR_THR_UC: rd_mux = thr_reg[THR_UC];
            ADDR_HYST: rd_mux = cfg_reg.hyst;
            ADDR_TMO: rd_mux = cfg_reg.tmo;
            ADDR_STAT: rd_mux = stat_word;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
        end
    end

    // ==========================================================
    // Checks
    AST_NO_THR_NORMAL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && cfg_reg.en == 4'h0) |=> (state_o == ST_NORMAL) && !evt_o.asrt)
        else $error("state not normal with all thresholds disabled");

    AST_UC_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && cfg_reg.en == 4'h8) |=> (state_o == ST_NORMAL || state_o == ST_UC))
        else $error("unreachable state with only upper critical enabled");

    AST_WARN_SEV: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_o == ST_UW || state_o == ST_LW) |-> severity_o == SEV_WARN)
        else $error("warning state has wrong severity");

    AST_CRIT_SEV: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_o == ST_UC || state_o == ST_LC) |-> severity_o == SEV_CRIT)
        else $error("critical state has wrong severity");

    AST_ZERO_TMO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && tmo_zero && cand_worse) |=> evt_o.asrt && (evt_o.state == state_o))
        else $error("zero timeout did not assert at once");

    AST_WAIT_FIRST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && cand_worse && !tmo_zero && !same_pend) |=> !evt_o.asrt && pending_o)
        else $error("worse state asserted without waiting");

    AST_CANCEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && pend_vld_reg && cand != pend_st_reg) |=> !evt_o.asrt)
        else $error("cancelled pending state was asserted");

    AST_DEASSERT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && cand_better) |=> evt_o.dasrt && state_o == $past(cand) && !pending_o)
        else $error("improving change did not de-assert");

    AST_HYST_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && state_reg == ST_UW && cfg_reg.en[THR_UW] && !cleared[THR_UW]
         && raw == ST_NORMAL) |=> state_o == ST_UW && !evt_o.dasrt)
        else $error("de-asserted inside the hysteresis band");

    // ==========================================================
    // Event checks
    // These look at the registered outputs one cycle after the tick,
    // which is what the notification logic downstream will see

    AST_UP_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && state_reg == ST_UW && cfg_reg.en[THR_UW] && raw == ST_NORMAL
         && rd_ext <= ($signed({thr_reg[THR_UW][DW-1], thr_reg[THR_UW]}) - hy_ext))
        |=> evt_o.dasrt && state_o == ST_NORMAL)
        else $error("upper de-assertion level reached without de-assertion");

    AST_LO_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && state_reg == ST_LW && cfg_reg.en[THR_LW] && raw == ST_NORMAL
         && rd_ext >= ($signed({thr_reg[THR_LW][DW-1], thr_reg[THR_LW]}) + hy_ext))
        |=> evt_o.dasrt && state_o == ST_NORMAL)
        else $error("lower de-assertion level reached without de-assertion");

    AST_ZERO_HYST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && state_reg == ST_UC && cfg_reg.en[THR_UC] && cfg_reg.hyst == HYST_RST
         && raw == ST_NORMAL) |=> evt_o.dasrt && state_o == ST_NORMAL)
        else $error("zero hysteresis did not release at the threshold");

    AST_TMO_EXPIRE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && same_pend && cnt_done && !tmo_zero) |=> evt_o.asrt && !pending_o)
        else $error("timeout expired without assertion");

    AST_TMO_COUNT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && same_pend && !cnt_done && !tmo_zero) |=> pending_o && !evt_o.asrt)
        else $error("asserted before the timeout expired");

    AST_BACK_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && cand == state_reg) |=> !pending_o && !evt_o.asrt && !evt_o.dasrt)
        else $error("return to asserted state left a pending assertion");

    AST_EVT_ON_SAMPLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (evt_o.asrt || evt_o.dasrt) |-> sample_o)
        else $error("event raised outside a sample");

    AST_ONE_EVT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        evt_o.asrt |-> !evt_o.dasrt)
        else $error("assertion and de-assertion in one sample");

    AST_DASRT_BETTER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        evt_o.dasrt |-> severity_o < $past(severity_o))
        else $error("de-assertion without improvement");

    AST_ASRT_NEW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        evt_o.asrt |-> evt_o.state == state_o && state_o != $past(state_o))
        else $error("assertion without a state change");

    AST_NORMAL_SEV: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_o == ST_NORMAL |-> severity_o == SEV_NORMAL)
        else $error("normal state has wrong severity");

    AST_UW_THREE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && cfg_reg.en == 4'hc && state_reg != ST_LW && state_reg != ST_LC)
        |=> (state_o == ST_NORMAL || state_o == ST_UW || state_o == ST_UC))
        else $error("unreachable state with upper thresholds only");

    AST_LC_BAND: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && tmo_zero && cfg_reg.en[3:2] == 2'b00 && cfg_reg.en[THR_LC]
         && state_reg != ST_LC
         && rd_ext < $signed({thr_reg[THR_LC][DW-1], thr_reg[THR_LC]}))
        |=> evt_o.asrt && state_o == ST_LC)
        else $error("reading under lower critical not asserted");

endmodule

/* File: verification/smon_src.sv */
`timescale 1ns/10ps
module smon_src import smon_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic sample_i,
    output logic signed [DW-1:0] reading_o
);
    logic signed [DW-1:0] feed_q[$];
    logic used_reg;

    initial begin
        reading_o = '0;
        used_reg = 1'b1;
    end

    // ==========================================================
    // Measurement source
    // A new reading is offered once the previous one was taken by a sample;
    // the last value is held because a sensor level never floats
    always @(posedge sys_clk_i) begin
        if (sample_i) begin
            used_reg <= 1'b1;
        end else if (used_reg && feed_q.size() > 0) begin
            reading_o <= feed_q.pop_front();
            used_reg <= 1'b0;
        end
    end

    task automatic push(input logic signed [DW-1:0] r);
        feed_q.push_back(r);
    endtask
endmodule

/* File: verification/smon_top_bench.sv */
`timescale 1ns/10ps
module smon_top_bench import smon_pkg::*; ;
    localparam int CPS = 16;
    typedef struct packed {
        smon_state_t st;
        logic [1:0] sev;
        logic asrt;
        logic dasrt;
        logic pend;
        logic [7:0] per;
    } smon_exp_t;

    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [AW-1:0] addr_i = '0;
    logic [DW-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DW-1:0] rdata_o;
    logic signed [DW-1:0] reading_i;
    logic sample_o;
    smon_evt_t evt_o;
    smon_state_t state_o;
    logic [1:0] severity_o;
    logic pending_o;
    int error_cnt = 0;
    int n_compared = 0;
    int gap = 0;
    logic rd_d = 1'b0;
    logic [31:0] lfsr = 32'h5ef83691;
    smon_exp_t exp_q[$];
    logic [DW-1:0] rd_q[$];

    always #4 sys_clk_i = ~sys_clk_i;

    smon_top #(.CYC_PER_SEC(CPS)) u_smon_top (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reading_i(reading_i),
        .sample_o(sample_o), .evt_o(evt_o), .state_o(state_o), .severity_o(severity_o),
        .pending_o(pending_o)
    );

    smon_src u_smon_src (.sys_clk_i(sys_clk_i), .sample_i(sample_o), .reading_o(reading_i));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic cmp_st(input smon_state_t got, input smon_state_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge sys_clk_i);
        rd_q.push_back(exp);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
    endtask

    // Config lands in the quiet gap right after a sample, so no tick sees a half-written set
    task automatic scen(input logic [4:0] ctrl, input logic [DW-1:0] hy, input logic [DW-1:0] tm);
        wait (exp_q.size() == 0);
        @(posedge sys_clk_i iff sample_o);
        bus_wr(ADDR_CTRL, {11'h000, ctrl});
        bus_wr(ADDR_HYST, hy);
        bus_wr(ADDR_TMO, tm);
    endtask

    task automatic step(input int r, input smon_state_t st, input logic [1:0] sv,
                        input logic [2:0] adp, input int per);
        u_smon_src.push(DW'(r));
        exp_q.push_back('{st, sv, adp[2], adp[1], adp[0], 8'(per)});
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Output monitor
    always @(posedge sys_clk_i) begin
        smon_exp_t e;
        gap <= sample_o ? 1 : gap + 1;
        rd_d <= rd_i;
        if (rd_d) begin
            cmp_val(rdata_o, rd_q.pop_front());
        end
        if (sample_o && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_st(state_o, e.st);
            cmp_val(16'(severity_o), 16'(e.sev));
            cmp_val({13'h0, evt_o.asrt, evt_o.dasrt, pending_o},
                    {13'h0, e.asrt, e.dasrt, e.pend});
            if (e.asrt || e.dasrt) begin
                cmp_st(evt_o.state, e.st);
            end
            if (e.per != 8'h00) begin
                cmp_val(16'(gap), 16'(e.per));
            end
        end
    end

    // ==========================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [DW-1:0] rv;
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            bus_rd(AW'(a), 16'h0000);
        end
        bus_rd(ADDR_STAT, 16'h0101);
        bus_rd(4'h8, 16'h0000);
        lfsr = lfsr_next(lfsr);
        rv = lfsr[DW-1:0];
        bus_wr(ADDR_HYST, rv);
        bus_rd(ADDR_HYST, rv);
        bus_wr(ADDR_STAT, rv);
        bus_rd(ADDR_STAT, 16'h0101);
        bus_wr(ADDR_THR_LC, 16'h000a);
        bus_wr(ADDR_THR_LW, 16'h0012);
        bus_wr(ADDR_THR_UW, 16'h0019);
        bus_wr(ADDR_THR_UC, 16'h0021);
        scen(5'h00, 16'h0000, 16'h0000);
        step(100, ST_NORMAL, SEV_NORMAL, 3'b000, 0);
        step(-100, ST_NORMAL, SEV_NORMAL, 3'b000, CPS);
        scen(5'h0f, 16'h0000, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            step(18 + int'(lfsr[2:0]), ST_NORMAL, SEV_NORMAL, 3'b000, 0);
        end
        scen(5'h08, 16'h0000, 16'h0000);
        step(34, ST_UC, SEV_CRIT, 3'b100, 0);
        step(33, ST_NORMAL, SEV_NORMAL, 3'b010, CPS);
        step(30, ST_NORMAL, SEV_NORMAL, 3'b000, CPS);
        step(34, ST_UC, SEV_CRIT, 3'b100, CPS);
        step(-5, ST_NORMAL, SEV_NORMAL, 3'b010, CPS);
        scen(5'h0c, 16'h0002, 16'h0002);
        step(26, ST_NORMAL, SEV_NORMAL, 3'b001, 0);
        step(26, ST_NORMAL, SEV_NORMAL, 3'b001, CPS);
        step(26, ST_UW, SEV_WARN, 3'b100, CPS);
        step(34, ST_UW, SEV_WARN, 3'b001, CPS);
        step(26, ST_UW, SEV_WARN, 3'b000, CPS);
        step(24, ST_UW, SEV_WARN, 3'b000, CPS);
        step(23, ST_NORMAL, SEV_NORMAL, 3'b010, CPS);
        step(34, ST_NORMAL, SEV_NORMAL, 3'b001, CPS);
        step(34, ST_NORMAL, SEV_NORMAL, 3'b001, CPS);
        step(34, ST_UC, SEV_CRIT, 3'b100, CPS);
        step(32, ST_UC, SEV_CRIT, 3'b000, CPS);
        step(31, ST_UW, SEV_WARN, 3'b010, CPS);
        step(23, ST_NORMAL, SEV_NORMAL, 3'b010, CPS);
        scen(5'h03, 16'h0002, 16'h0000);
        step(17, ST_LW, SEV_WARN, 3'b100, 0);
        step(10, ST_LW, SEV_WARN, 3'b000, CPS);
        step(9, ST_LC, SEV_CRIT, 3'b100, CPS);
        step(11, ST_LC, SEV_CRIT, 3'b000, CPS);
        step(12, ST_LW, SEV_WARN, 3'b010, CPS);
        step(19, ST_LW, SEV_WARN, 3'b000, CPS);
        step(20, ST_NORMAL, SEV_NORMAL, 3'b010, CPS);
        scen(5'h10, 16'h0000, 16'h0000);
        step(0, ST_NORMAL, SEV_NORMAL, 3'b000, 0);
        step(0, ST_NORMAL, SEV_NORMAL, 3'b000, 3 * CPS);
        step(0, ST_NORMAL, SEV_NORMAL, 3'b000, 3 * CPS);
        wait (exp_q.size() == 0);
        repeat (2) @(posedge sys_clk_i);
        end_of_test();
    end
endmodule
